// ### rtl/port_pin_edge_detect.sv
`timescale 1ns/100ps
// Notes on behaviour
// - port 1 falling edge on an enabled pin sets its falling status bit.
// - port 1 falling status holds until software writes zero to that bit.
// - set port 1 falling status raises pin interrupt when port enable is on.
// - writing one to a port 1 falling enable bit turns detection on.
// - port 2 rising edge on an enabled pin sets its rising status bit.
// - port 2 rising status holds until software writes zero to that bit.
// - set port 2 rising status raises pin interrupt when port enable is on.
// - writing one to a port 2 rising enable bit turns detection on.
// - port 2 falling edge on an enabled pin sets its falling status bit.
// - port 2 falling status holds until software writes zero to that bit.
// - set port 2 falling status raises pin interrupt when port enable is on.
// - writing one to a port 2 falling enable bit turns detection on.
// - port 3 rising edge on an enabled pin sets its rising status bit.
// - port 3 rising status holds until software writes zero to that bit.
// - set port 3 rising status raises pin interrupt when port enable is on.
// - writing one to a port 3 rising enable bit turns detection on.
// - port 3 falling edge on an enabled pin sets its falling status bit.
// - port 3 falling status holds until software writes zero to that bit.
// - set port 3 falling status raises pin interrupt when port enable is on.
// - writing one to a port 3 falling enable bit turns detection on.
// - routing bits feed pins into interrupt a, b, or both; many pins allowed.
module port_pin_edge_detect #(
  parameter int PinCount = edge_detect_pkg::PIN_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [edge_detect_pkg::ADDR_W-1:0] regAddr,
  input wire logic [PinCount-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [PinCount-1:0] regRdata,
  // port pins
  input wire logic [PinCount-1:0] port1Pins,
  input wire logic [PinCount-1:0] port2Pins,
  input wire logic [PinCount-1:0] port3Pins,
  // interrupt configuration, port 1 in the low bits
  input wire logic [edge_detect_pkg::PORT_COUNT-1:0] portPinIrqEnable,
  input wire logic [edge_detect_pkg::PORT_COUNT*PinCount-1:0] routeToPinIrqA,
  input wire logic [edge_detect_pkg::PORT_COUNT*PinCount-1:0] routeToPinIrqB,
  // pin interrupt requests
  output logic pinIrqA,
  output logic pinIrqB
);

  // ==========================================================
  // address decode
  wire hitP1Fall = regAddr == edge_detect_pkg::OFF_P1_FALL;
  wire hitP2Rise = regAddr == edge_detect_pkg::OFF_P2_RISE;
  wire hitP2Fall = regAddr == edge_detect_pkg::OFF_P2_FALL;
  wire hitP3Rise = regAddr == edge_detect_pkg::OFF_P3_RISE;
  wire hitP3Fall = regAddr == edge_detect_pkg::OFF_P3_FALL;

  // ==========================================================
  // detection lanes
  detect_lane_if #(.W(PinCount)) p1Fall ();
  detect_lane_if #(.W(PinCount)) p2Rise ();
  detect_lane_if #(.W(PinCount)) p2Fall ();
  detect_lane_if #(.W(PinCount)) p3Rise ();
  detect_lane_if #(.W(PinCount)) p3Fall ();

  // one write clears status zeros and loads enables in the same cycle
  assign p1Fall.wrStb = regWr & hitP1Fall;
  assign p2Rise.wrStb = regWr & hitP2Rise;
  assign p2Fall.wrStb = regWr & hitP2Fall;
  assign p3Rise.wrStb = regWr & hitP3Rise;
  assign p3Fall.wrStb = regWr & hitP3Fall;
  assign p1Fall.wrData = regWdata;
  assign p2Rise.wrData = regWdata;
  assign p2Fall.wrData = regWdata;
  assign p3Rise.wrData = regWdata;
  assign p3Fall.wrData = regWdata;

  // each lane keeps its own synchroniser; costs a few flops, keeps lanes independent
  edge_lane #(.W(PinCount), .RISING(1'b0)) p1FallLane (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinIn(port1Pins),
    .bus(p1Fall.lane)
  );

  edge_lane #(.W(PinCount), .RISING(1'b1)) p2RiseLane (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinIn(port2Pins),
    .bus(p2Rise.lane)
  );

  edge_lane #(.W(PinCount), .RISING(1'b0)) p2FallLane (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinIn(port2Pins),
    .bus(p2Fall.lane)
  );

  edge_lane #(.W(PinCount), .RISING(1'b1)) p3RiseLane (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinIn(port3Pins),
    .bus(p3Rise.lane)
  );

  edge_lane #(.W(PinCount), .RISING(1'b0)) p3FallLane (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinIn(port3Pins),
    .bus(p3Fall.lane)
  );

  // ==========================================================
  // read data, valid only in the cycle after the read strobe
  logic [PinCount-1:0] rdata_ff;
  wire [PinCount-1:0] nxt_rdata =
    hitP1Fall ? p1Fall.status :
    hitP2Rise ? p2Rise.status :
    hitP2Fall ? p2Fall.status :
    hitP3Rise ? p3Rise.status :
    hitP3Fall ? p3Fall.status : {PinCount{1'b0}};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= PinCount'(edge_detect_pkg::RDATA_RESET);
    end else begin
      rdata_ff <= regRd ? nxt_rdata : {PinCount{1'b0}};
    end
  end

  assign regRdata = rdata_ff;

  // ==========================================================
  // pin interrupt requests
  wire [PinCount-1:0] p1Pend = p1Fall.status & {PinCount{portPinIrqEnable[edge_detect_pkg::PORT1_IDX]}};
  wire [PinCount-1:0] p2Pend = (p2Rise.status | p2Fall.status) &
    {PinCount{portPinIrqEnable[edge_detect_pkg::PORT2_IDX]}};
  wire [PinCount-1:0] p3Pend = (p3Rise.status | p3Fall.status) &
    {PinCount{portPinIrqEnable[edge_detect_pkg::PORT3_IDX]}};
  wire [edge_detect_pkg::PORT_COUNT*PinCount-1:0] pendAll = {p3Pend, p2Pend, p1Pend};
  // one pin may feed both requests
  wire nxt_irqA = |(pendAll & routeToPinIrqA);
  wire nxt_irqB = |(pendAll & routeToPinIrqB);
  logic irqA_ff;
  logic irqB_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqA_ff <= 1'b0;
      irqB_ff <= 1'b0;
    end else begin
      irqA_ff <= nxt_irqA;
      irqB_ff <= nxt_irqB;
    end
  end

  assign pinIrqA = irqA_ff;
  assign pinIrqB = irqB_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  wire [PinCount-1:0] p1FallSet = p1Fall.seen & p1Fall.enable;
  wire [PinCount-1:0] p2RiseSet = p2Rise.seen & p2Rise.enable;
  wire [PinCount-1:0] p2FallSet = p2Fall.seen & p2Fall.enable;
  wire [PinCount-1:0] p3RiseSet = p3Rise.seen & p3Rise.enable;
  wire [PinCount-1:0] p3FallSet = p3Fall.seen & p3Fall.enable;

  sequence s_write(logic stb);
    stb ##1 1'b1;
  endsequence

  sequence s_idle(logic stb, logic [PinCount-1:0] setv);
    !stb && setv == '0;
  endsequence

  // an enabled edge lands in status on the next cycle
  property p_set(logic [PinCount-1:0] setv, logic [PinCount-1:0] st);
    (setv != '0) |=> ((st & $past(setv)) == $past(setv));
  endproperty

  // without a write and without an edge status holds
  property p_hold(logic stb, logic [PinCount-1:0] setv, logic [PinCount-1:0] st);
    s_idle(stb, setv) |=> (st == $past(st));
  endproperty

  // a written zero clears unless an edge arrives in that cycle
  property p_clear(logic stb, logic [PinCount-1:0] wd, logic [PinCount-1:0] setv,
                   logic [PinCount-1:0] st);
    s_write(stb) |-> (st == (($past(st) & $past(wd)) | $past(setv)));
  endproperty

  // enable takes the written byte and keeps it
  property p_enable(logic stb, logic [PinCount-1:0] wd, logic [PinCount-1:0] en);
    stb |=> (en == $past(wd)) ##1 ($past(stb) || $stable(en));
  endproperty

  // an edge on a disabled pin never sets status
  property p_gate(logic [PinCount-1:0] seen, logic [PinCount-1:0] en,
                  logic [PinCount-1:0] st, logic stb);
    (!stb && (seen & ~en & ~st) != '0) |=> ((st & $past(seen & ~en & ~st)) == '0);
  endproperty

  a_p1_fall_set: assert property (p_set(p1FallSet, p1Fall.status))
    else $error("port 1 falling status not set by edge");
  a_p1_fall_hold: assert property (p_hold(p1Fall.wrStb, p1FallSet, p1Fall.status))
    else $error("port 1 falling status changed without cause");
  a_p1_fall_clear: assert property (p_clear(p1Fall.wrStb, regWdata, p1FallSet, p1Fall.status))
    else $error("port 1 falling status clear wrong");
  a_p1_fall_enable: assert property (p_enable(p1Fall.wrStb, regWdata, p1Fall.enable))
    else $error("port 1 falling enable not loaded");
  a_p1_fall_gate: assert property (p_gate(p1Fall.seen, p1Fall.enable, p1Fall.status, p1Fall.wrStb))
    else $error("port 1 falling status set while disabled");

  a_p2_rise_set: assert property (p_set(p2RiseSet, p2Rise.status))
    else $error("port 2 rising status not set by edge");
  a_p2_rise_hold: assert property (p_hold(p2Rise.wrStb, p2RiseSet, p2Rise.status))
    else $error("port 2 rising status changed without cause");
  a_p2_rise_clear: assert property (p_clear(p2Rise.wrStb, regWdata, p2RiseSet, p2Rise.status))
    else $error("port 2 rising status clear wrong");
  a_p2_rise_enable: assert property (p_enable(p2Rise.wrStb, regWdata, p2Rise.enable))
    else $error("port 2 rising enable not loaded");

  a_p2_fall_set: assert property (p_set(p2FallSet, p2Fall.status))
    else $error("port 2 falling status not set by edge");
  a_p2_fall_hold: assert property (p_hold(p2Fall.wrStb, p2FallSet, p2Fall.status))
    else $error("port 2 falling status changed without cause");
  a_p2_fall_clear: assert property (p_clear(p2Fall.wrStb, regWdata, p2FallSet, p2Fall.status))
    else $error("port 2 falling status clear wrong");
  a_p2_fall_enable: assert property (p_enable(p2Fall.wrStb, regWdata, p2Fall.enable))
    else $error("port 2 falling enable not loaded");

  a_p3_rise_set: assert property (p_set(p3RiseSet, p3Rise.status))
    else $error("port 3 rising status not set by edge");
  a_p3_rise_hold: assert property (p_hold(p3Rise.wrStb, p3RiseSet, p3Rise.status))
    else $error("port 3 rising status changed without cause");
  a_p3_rise_clear: assert property (p_clear(p3Rise.wrStb, regWdata, p3RiseSet, p3Rise.status))
    else $error("port 3 rising status clear wrong");
  a_p3_rise_enable: assert property (p_enable(p3Rise.wrStb, regWdata, p3Rise.enable))
    else $error("port 3 rising enable not loaded");

  a_p3_fall_set: assert property (p_set(p3FallSet, p3Fall.status))
    else $error("port 3 falling status not set by edge");
  a_p3_fall_hold: assert property (p_hold(p3Fall.wrStb, p3FallSet, p3Fall.status))
    else $error("port 3 falling status changed without cause");
  a_p3_fall_clear: assert property (p_clear(p3Fall.wrStb, regWdata, p3FallSet, p3Fall.status))
    else $error("port 3 falling status clear wrong");
  a_p3_fall_enable: assert property (p_enable(p3Fall.wrStb, regWdata, p3Fall.enable))
    else $error("port 3 falling enable not loaded");

  a_p2_rise_gate: assert property (p_gate(p2Rise.seen, p2Rise.enable, p2Rise.status, p2Rise.wrStb))
    else $error("port 2 rising status set while disabled");
  a_p2_fall_gate: assert property (p_gate(p2Fall.seen, p2Fall.enable, p2Fall.status, p2Fall.wrStb))
    else $error("port 2 falling status set while disabled");
  a_p3_rise_gate: assert property (p_gate(p3Rise.seen, p3Rise.enable, p3Rise.status, p3Rise.wrStb))
    else $error("port 3 rising status set while disabled");
  a_p3_fall_gate: assert property (p_gate(p3Fall.seen, p3Fall.enable, p3Fall.status, p3Fall.wrStb))
    else $error("port 3 falling status set while disabled");

  // a settled change counts once; the level follows in the next cycle
  a_p1_seen_pulse: assert property (
    (p1Fall.seen != '0) |=> ((p1Fall.seen & $past(p1Fall.seen)) == '0))
    else $error("port 1 falling edge counted twice");
  a_p2_seen_pulse: assert property (
    (p2Rise.seen != '0) |=> ((p2Rise.seen & $past(p2Rise.seen)) == '0))
    else $error("port 2 rising edge counted twice");

  // interrupt follows routed, enabled status one cycle later
  a_p1_irq_raise: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT1_IDX] &&
     (p1Fall.status & routeToPinIrqA[PinCount-1:0]) != '0) |=> pinIrqA)
    else $error("port 1 falling status did not raise interrupt a");
  a_p2_irq_raise: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT2_IDX] &&
     (p2Rise.status & routeToPinIrqA[2*PinCount-1:PinCount]) != '0) |=> pinIrqA)
    else $error("port 2 rising status did not raise interrupt a");
  a_p2f_irq_raise: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT2_IDX] &&
     (p2Fall.status & routeToPinIrqB[2*PinCount-1:PinCount]) != '0) |=> pinIrqB)
    else $error("port 2 falling status did not raise interrupt b");
  a_p3_irq_raise: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT3_IDX] &&
     (p3Rise.status & routeToPinIrqA[3*PinCount-1:2*PinCount]) != '0) |=> pinIrqA)
    else $error("port 3 rising status did not raise interrupt a");
  a_p3f_irq_raise: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT3_IDX] &&
     (p3Fall.status & routeToPinIrqB[3*PinCount-1:2*PinCount]) != '0) |=> pinIrqB)
    else $error("port 3 falling status did not raise interrupt b");
  a_irq_quiet: assert property (
    (portPinIrqEnable == '0) |=> (!pinIrqA && !pinIrqB))
    else $error("interrupt raised with every port disabled");
  a_irq_both: assert property (
    ((pendAll & routeToPinIrqA & routeToPinIrqB) != '0) |=> (pinIrqA && pinIrqB))
    else $error("pin routed to both did not raise both");

  // the other request line of every lane
  a_p1_irq_b: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT1_IDX] &&
     (p1Fall.status & routeToPinIrqB[PinCount-1:0]) != '0) |=> pinIrqB)
    else $error("port 1 falling status did not raise interrupt b");
  a_p2_irq_b: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT2_IDX] &&
     (p2Rise.status & routeToPinIrqB[2*PinCount-1:PinCount]) != '0) |=> pinIrqB)
    else $error("port 2 rising status did not raise interrupt b");
  a_p2f_irq_a: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT2_IDX] &&
     (p2Fall.status & routeToPinIrqA[2*PinCount-1:PinCount]) != '0) |=> pinIrqA)
    else $error("port 2 falling status did not raise interrupt a");
  a_p3_irq_b: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT3_IDX] &&
     (p3Rise.status & routeToPinIrqB[3*PinCount-1:2*PinCount]) != '0) |=> pinIrqB)
    else $error("port 3 rising status did not raise interrupt b");
  a_p3f_irq_a: assert property (
    (portPinIrqEnable[edge_detect_pkg::PORT3_IDX] &&
     (p3Fall.status & routeToPinIrqA[3*PinCount-1:2*PinCount]) != '0) |=> pinIrqA)
    else $error("port 3 falling status did not raise interrupt a");
  a_irq_a_low: assert property (
    ((pendAll & routeToPinIrqA) == '0) |=> !pinIrqA)
    else $error("interrupt a raised with nothing pending");
  a_irq_b_low: assert property (
    ((pendAll & routeToPinIrqB) == '0) |=> !pinIrqB)
    else $error("interrupt b raised with nothing pending");

  // read answers only in the following cycle
  a_read_data: assert property (
    (regRd && hitP2Rise) |=> (regRdata == $past(p2Rise.status)))
    else $error("read data does not show status");
  a_read_idle: assert property (
    !regRd |=> (regRdata == '0))
    else $error("read data driven without a read");
  a_read_p1_fall: assert property (
    (regRd && hitP1Fall) |=> (regRdata == $past(p1Fall.status)))
    else $error("read data does not show port 1 falling status");
  a_read_p2_fall: assert property (
    (regRd && hitP2Fall) |=> (regRdata == $past(p2Fall.status)))
    else $error("read data does not show port 2 falling status");
  a_read_p3_rise: assert property (
    (regRd && hitP3Rise) |=> (regRdata == $past(p3Rise.status)))
    else $error("read data does not show port 3 rising status");
  a_read_p3_fall: assert property (
    (regRd && hitP3Fall) |=> (regRdata == $past(p3Fall.status)))
    else $error("read data does not show port 3 falling status");

endmodule : port_pin_edge_detect

// ### rtl/edge_detect_pkg.sv
package edge_detect_pkg;

  // ==========================================================
  // widths
  localparam int PIN_W = 8;
  localparam int ADDR_W = 16;

  // ==========================================================
  // register offsets, byte addresses on the register port
  localparam logic [ADDR_W-1:0] OFF_P2_RISE = 16'ha02a;
  localparam logic [ADDR_W-1:0] OFF_P3_RISE = 16'ha02b;
  localparam logic [ADDR_W-1:0] OFF_P1_FALL = 16'ha039;
  localparam logic [ADDR_W-1:0] OFF_P2_FALL = 16'ha03a;
  localparam logic [ADDR_W-1:0] OFF_P3_FALL = 16'ha03b;

  // ==========================================================
  // reset values
  localparam logic [PIN_W-1:0] DETECT_RESET = 8'h00;
  localparam logic [PIN_W-1:0] RDATA_RESET = 8'h00;

  // ==========================================================
  // port positions in the enable vector and in the routing vectors
  localparam int PORT1_IDX = 0;
  localparam int PORT2_IDX = 1;
  localparam int PORT3_IDX = 2;
  localparam int PORT_COUNT = 3;

  // ==========================================================
  // cycles after reset before the pin synchroniser holds real samples
  localparam int SYNC_FILL = 3;

endpackage : edge_detect_pkg

// ### rtl/detect_lane_if.sv
`timescale 1ns/100ps
interface detect_lane_if #(parameter int W = 8);
  logic wrStb;
  logic [W-1:0] wrData;
  logic [W-1:0] enable;
  logic [W-1:0] status;
  logic [W-1:0] seen;

  modport ctrl (
    output wrStb,
    output wrData,
    input enable,
    input status,
    input seen
  );

  modport lane (
    input wrStb,
    input wrData,
    output enable,
    output status,
    output seen
  );
endinterface : detect_lane_if

// ### rtl/edge_lane.sv
`timescale 1ns/100ps
module edge_lane #(
  parameter int W = 8,
  parameter bit RISING = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // pins, asynchronous to clk_sys
  input wire logic [W-1:0] pinIn,
  // register side
  detect_lane_if.lane bus
);

  // ==========================================================
  // pin synchroniser and settled level
  logic [W-1:0] sync1_ff;
  logic [W-1:0] sync2_ff;
  logic [W-1:0] sync3_ff;
  logic [W-1:0] level_ff;
  logic [edge_detect_pkg::SYNC_FILL-1:0] fill_ff;
  logic primed_ff;
  logic [W-1:0] enable_ff;
  logic [W-1:0] status_ff;

  // a change counts only once stages two and three agree
  wire [W-1:0] agree = ~(sync2_ff ^ sync3_ff);
  wire [W-1:0] nxt_level = (agree & sync3_ff) | (~agree & level_ff);
  wire [W-1:0] riseSeen = {W{primed_ff}} & agree & sync3_ff & ~level_ff;
  wire [W-1:0] fallSeen = {W{primed_ff}} & agree & ~sync3_ff & level_ff;
  wire [W-1:0] edgeSeen = RISING ? riseSeen : fallSeen;
  wire [W-1:0] setMask = edgeSeen & enable_ff;
  wire [W-1:0] clrMask = bus.wrStb ? ~bus.wrData : {W{1'b0}};
  // set wins over a clear in the same cycle
  wire [W-1:0] nxt_status = (status_ff & ~clrMask) | setMask;
  wire [W-1:0] nxt_enable = bus.wrStb ? bus.wrData : enable_ff;
  // first settled sample loads the level without counting an edge
  wire nxt_primed = primed_ff | fill_ff[edge_detect_pkg::SYNC_FILL-1];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      level_ff <= '0;
      fill_ff <= '0;
      primed_ff <= 1'b0;
    end else begin
      sync1_ff <= pinIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      level_ff <= nxt_level;
      fill_ff <= {fill_ff[edge_detect_pkg::SYNC_FILL-2:0], 1'b1};
      primed_ff <= nxt_primed;
    end
  end

  // ==========================================================
  // enable and latched status
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      enable_ff <= W'(edge_detect_pkg::DETECT_RESET);
      status_ff <= W'(edge_detect_pkg::DETECT_RESET);
    end else begin
      enable_ff <= nxt_enable;
      status_ff <= nxt_status;
    end
  end

  assign bus.enable = enable_ff;
  assign bus.status = status_ff;
  assign bus.seen = edgeSeen;

endmodule : edge_lane

// ### testbench/ext_pins.sv
`timescale 1ns/100ps
// ==========================================================
// external pin drivers for the three ports
module ext_pins (
  // clock
  input wire logic clk_sys,
  // pin levels
  output logic [edge_detect_pkg::PIN_W-1:0] port1Pins,
  output logic [edge_detect_pkg::PIN_W-1:0] port2Pins,
  output logic [edge_detect_pkg::PIN_W-1:0] port3Pins
);
  initial begin
    port1Pins = 8'h00;
    port2Pins = 8'h00;
    port3Pins = 8'h00;
  end

  // levels hold until the next change, like a strapped pin
  task automatic drive(input int port, input logic [edge_detect_pkg::PIN_W-1:0] lvl);
    @(posedge clk_sys);
    case (port)
      0: port1Pins <= lvl;
      1: port2Pins <= lvl;
      default: port3Pins <= lvl;
    endcase
  endtask : drive
endmodule : ext_pins

// ### testbench/port_pin_edge_detect_tb.sv
`timescale 1ns/100ps
module port_pin_edge_detect_tb;
  // ==========================================================
  // signals
  logic clk_sys;
  logic resetn;
  logic [15:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic [7:0] regRdata;
  logic [7:0] port1Pins;
  logic [7:0] port2Pins;
  logic [7:0] port3Pins;
  logic [2:0] portPinIrqEnable;
  logic [23:0] routeToPinIrqA;
  logic [23:0] routeToPinIrqB;
  logic pinIrqA;
  logic pinIrqB;
  int n_errors;
  int n_checks;
  logic [15:0] addrTab [5];
  int portTab [5];
  bit riseTab [5];

  // ==========================================================
  // instances
  port_pin_edge_detect port_pin_edge_detect_inst (
    .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .port1Pins(port1Pins), .port2Pins(port2Pins),
    .port3Pins(port3Pins), .portPinIrqEnable(portPinIrqEnable), .routeToPinIrqA(routeToPinIrqA),
    .routeToPinIrqB(routeToPinIrqB), .pinIrqA(pinIrqA), .pinIrqB(pinIrqB)
  );
  ext_pins ext_pins_inst (
    .clk_sys(clk_sys), .port1Pins(port1Pins), .port2Pins(port2Pins), .port3Pins(port3Pins)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // access tasks
  task automatic check(input string name, input logic [7:0] expv, input logic [7:0] seen);
    n_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  task automatic regWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : regWrite

  // data stands one cycle only, then must drop back to zero
  task automatic rdCheck(input logic [15:0] a, input logic [7:0] expv, input string name);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check(name, expv, regRdata);
    @(posedge clk_sys);
    #1;
    check("read data idle", 8'h00, regRdata);
  endtask : rdCheck

  task automatic irqCheck(input logic [1:0] expv, input string name);
    #1;
    check(name, {6'h00, expv}, {6'h00, pinIrqA, pinIrqB});
  endtask : irqCheck

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // one lane: enable, edge, interrupt, partial clear, disabled pins
  task automatic runLane(input int r);
    int p;
    logic [7:0] base;
    p = portTab[r];
    base = riseTab[r] ? 8'h00 : 8'hff;
    ext_pins_inst.drive(p, base);
    repeat (6) @(posedge clk_sys);
    regWrite(addrTab[r], 8'hff);
    ext_pins_inst.drive(p, base ^ 8'ha5);
    repeat (8) @(posedge clk_sys);
    rdCheck(addrTab[r], 8'ha5, "status set");
    @(posedge clk_sys);
    routeToPinIrqA <= 24'h000005 << (8 * p);
    routeToPinIrqB <= 24'h0000a0 << (8 * p);
    portPinIrqEnable <= 3'h1 << p;
    repeat (3) @(posedge clk_sys);
    irqCheck(2'b11, "irq routed");
    portPinIrqEnable <= ~(3'h1 << p);
    repeat (3) @(posedge clk_sys);
    irqCheck(2'b00, "irq other port enable");
    portPinIrqEnable <= 3'h1 << p;
    regWrite(addrTab[r], 8'hf0);
    rdCheck(addrTab[r], 8'ha0, "partial clear");
    irqCheck(2'b01, "irq after clear");
    ext_pins_inst.drive(p, base ^ 8'haa);
    repeat (8) @(posedge clk_sys);
    rdCheck(addrTab[r], 8'ha0, "disabled pins");
    regWrite(addrTab[r], 8'h00);
    rdCheck(addrTab[r], 8'h00, "full clear");
    @(posedge clk_sys);
    portPinIrqEnable <= 3'h0;
    $display("test lane %0d done", r);
  endtask : runLane

  // ==========================================================
  // main sequence
  initial begin
    addrTab = '{edge_detect_pkg::OFF_P1_FALL, edge_detect_pkg::OFF_P2_RISE, edge_detect_pkg::OFF_P2_FALL,
                edge_detect_pkg::OFF_P3_RISE, edge_detect_pkg::OFF_P3_FALL};
    portTab = '{0, 1, 1, 2, 2};
    riseTab = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    n_errors = 0;
    n_checks = 0;
    resetn = 1'b0;
    regAddr = 16'h0000;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    portPinIrqEnable = 3'h0;
    routeToPinIrqA = 24'h000000;
    routeToPinIrqB = 24'h000000;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      rdCheck(addrTab[r], edge_detect_pkg::DETECT_RESET, "reset value");
    end
    regWrite(16'ha028, 8'hff);
    rdCheck(16'ha028, 8'h00, "unmapped read");
    $display("test reset and map done");
    for (int r = 0; r < 5; r++) begin
      runLane(r);
    end
    tally_and_finish();
  end

  // lanes take about 51 cycles each; allow generous margin
  initial begin
    #(25 * 4000);
    n_errors++;
    tally_and_finish();
  end
endmodule : port_pin_edge_detect_tb
